// ===== core/fau_defs.svh
/*
  constants of the floating-point arithmetic unit: opcodes, ieee single fields, error code.
  assumes inclusion by bare name from every file that needs them.
*/
`ifndef FAU_DEFS_SVH
`define FAU_DEFS_SVH

// ----------------------------------------
// operation codes
// ----------------------------------------
`define FAU_OP_ADD 2'h0
`define FAU_OP_SUB 2'h1
`define FAU_OP_MUL 2'h2
`define FAU_OP_DIV 2'h3

// ----------------------------------------
// single precision layout
// ----------------------------------------
`define FAU_SIGN_POS 31
`define FAU_EXP_HI 30
`define FAU_EXP_LO 23
`define FAU_FRAC_HI 22
`define FAU_EXP_ZERO 8'h00
`define FAU_EXP_INF 8'hFF
`define FAU_BIAS 11'sh07F
`define FAU_HID_POS 6'h2E
`define FAU_ONE 11'sh001
`define FAU_ZERO_E 11'sh000
`define FAU_INF_E 11'sh0FF

// ----------------------------------------
// result word slices of the 48-bit working mantissa
// ----------------------------------------
`define FAU_MANT_TOP 45
`define FAU_MANT_LOW 23

// ----------------------------------------
// divider and error code
// ----------------------------------------
`define FAU_QBITS 27
`define FAU_QCNT_INIT 5'h1B
`define FAU_ERR_DIV0 16'h0E19

`endif

// ===== core/fau_pkg.sv
/*
  types of the floating-point arithmetic unit.
  assumes nothing beyond the defs header.
*/
package fau_pkg;

  typedef enum logic [1:0] {
    FAU_ADD = 2'h0,
    FAU_SUB = 2'h1,
    FAU_MUL = 2'h2,
    FAU_DIV = 2'h3
  } fau_op_t;

  typedef enum logic {
    FAU_ST_IDLE = 1'b0,
    FAU_ST_DIV = 1'b1
  } fau_state_t;

endpackage : fau_pkg

// ===== core/fau_mant_div.sv
/*
  restoring mantissa divider, one quotient bit per clock.
  assumes divisor is nonzero and normalised (bit 23 set) while busy.
*/
`timescale 1ns/1ps
`include "fau_defs.svh"

module fau_mant_div (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [23:0] dividend_i,
  input wire logic [23:0] divisor_i,
  output logic done_o,
  output logic [`FAU_QBITS-1:0] quot_o
);

  logic [25:0] rem_q;
  logic [23:0] dvs_q;
  logic [4:0] cnt_q;
  logic [25:0] diff;
  logic ge;

  assign diff = rem_q - {2'b00, dvs_q};
  assign ge = rem_q >= {2'b00, dvs_q};

  // ----------------------------------------
  // shift and subtract
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rem_q <= 26'h000_0000;
      dvs_q <= 24'h00_0000;
      cnt_q <= 5'h00;
      quot_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        rem_q <= {2'b00, dividend_i};
        dvs_q <= divisor_i;
        cnt_q <= `FAU_QCNT_INIT;
        quot_o <= '0;
      end
      else if (cnt_q != 5'h00)
      begin
        rem_q <= ge ? {diff[24:0], 1'b0} : {rem_q[24:0], 1'b0};
        quot_o <= {quot_o[`FAU_QBITS-2:0], ge};
        cnt_q <= cnt_q - 5'h01;
        done_o <= (cnt_q == 5'h01);
      end
    end
  end

endmodule : fau_mant_div

// ===== core/fau_top.sv
/*
  32-bit floating-point add, subtract, multiply and divide with status and error flags.
  assumes the issuing logic holds operands only in the start cycle; a start while busy_o is high is ignored.
*/
`timescale 1ns/1ps
`include "fau_defs.svh"

module fau_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [1:0] op_i,
  input wire logic first_operand_imm_i,
  input wire logic [31:0] first_operand_imm_val_i,
  input wire logic [15:0] first_operand_lo_i,
  input wire logic [15:0] first_operand_hi_i,
  input wire logic second_operand_imm_i,
  input wire logic [31:0] second_operand_imm_val_i,
  input wire logic [15:0] second_operand_lo_i,
  input wire logic [15:0] second_operand_hi_i,
  input wire logic err_latch_clr_i,
  output logic busy_o,
  output logic done_o,
  output logic wr_en_o,
  output logic [15:0] dest_lo_o,
  output logic [15:0] dest_hi_o,
  output logic carry_flag_o,
  output logic borrow_flag_o,
  output logic zero_flag_o,
  output logic operation_error_flag_o,
  output logic operation_error_latch_flag_o,
  output logic [15:0] error_code_register_o
);

  // ----------------------------------------
  // normalise and pack: {carry, borrow, zero, word}
  // ----------------------------------------
  // truncation is used, no rounding; denormals are flushed to zero
  function automatic logic [34:0] fau_pack(input logic s, input logic signed [10:0] e, input logic [47:0] m);
    logic [5:0] p;
    logic [5:0] sh;
    logic [47:0] mn;
    logic signed [10:0] en;
    logic [34:0] r;
    p = 6'h00;
    for (int i = 0; i < 48; i++)
      if (m[i])
        p = 6'(i);
    sh = `FAU_HID_POS - p;
    if (m[47])
    begin
      mn = m >> 1;
      en = e + `FAU_ONE;
    end
    else
    begin
      mn = m << sh;
      en = e - $signed({5'h00, sh});
    end
    if (m == 48'h0000_0000_0000)
      r = {3'b001, 1'b0, 31'h0000_0000};
    else if (en >= `FAU_INF_E)
      r = {3'b100, s, `FAU_EXP_INF, 23'h00_0000};
    else if (en <= `FAU_ZERO_E)
      r = {3'b010, s, 31'h0000_0000};
    else
      r = {3'b000, s, en[7:0], mn[`FAU_MANT_TOP:`FAU_MANT_LOW]};
    return r;
  endfunction : fau_pack

  // ----------------------------------------
  // operand fetch
  // ----------------------------------------
  logic [31:0] opa;
  logic [31:0] opb;
  assign opa = first_operand_imm_i ? first_operand_imm_val_i : {first_operand_hi_i, first_operand_lo_i};
  assign opb = second_operand_imm_i ? second_operand_imm_val_i : {second_operand_hi_i, second_operand_lo_i};
  logic [7:0] ea;
  logic [7:0] eb;
  logic [23:0] ma;
  logic [23:0] mb;
  logic sa;
  logic sb;
  assign ea = opa[`FAU_EXP_HI:`FAU_EXP_LO];
  assign eb = opb[`FAU_EXP_HI:`FAU_EXP_LO];
  assign ma = (ea == `FAU_EXP_ZERO) ? 24'h00_0000 : {1'b1, opa[`FAU_FRAC_HI:0]};
  assign mb = (eb == `FAU_EXP_ZERO) ? 24'h00_0000 : {1'b1, opb[`FAU_FRAC_HI:0]};
  assign sa = opa[`FAU_SIGN_POS];
  assign sb = opb[`FAU_SIGN_POS] ^ (op_i == `FAU_OP_SUB);

  // ----------------------------------------
  // add / subtract path
  // ----------------------------------------
  logic a_big;
  logic [7:0] ebig;
  logic [7:0] ediff;
  logic [47:0] mbig;
  logic [47:0] msml;
  logic [47:0] msum;
  logic sbig;
  assign a_big = {ea, ma} >= {eb, mb};
  assign ebig = a_big ? ea : eb;
  assign ediff = a_big ? (ea - eb) : (eb - ea);
  assign sbig = a_big ? sa : sb;
  assign mbig = {1'b0, (a_big ? ma : mb), 23'h00_0000};
  assign msml = {1'b0, (a_big ? mb : ma), 23'h00_0000} >> ediff;
  assign msum = (sa == sb) ? (mbig + msml) : (mbig - msml);

  // ----------------------------------------
  // multiply path
  // ----------------------------------------
  logic [47:0] mprod;
  logic signed [10:0] emul;
  assign mprod = ma * mb;
  assign emul = $signed({3'b000, ea}) + $signed({3'b000, eb}) - `FAU_BIAS;
  logic [34:0] add_res;
  logic [34:0] mul_res;
  assign add_res = fau_pack(sbig, $signed({3'b000, ebig}), msum);
  assign mul_res = fau_pack(sa ^ sb, emul, mprod);

  // ----------------------------------------
  // divide path
  // ----------------------------------------
  fau_pkg::fau_state_t state_q;
  logic accept;
  logic is_div;
  logic div_zero;
  logic div_go;
  logic div_done;
  logic [`FAU_QBITS-1:0] quot;
  logic div_s_q;
  logic signed [10:0] div_e_q;
  logic [34:0] div_res;

  assign accept = start_i && (state_q == fau_pkg::FAU_ST_IDLE);
  assign is_div = (op_i == `FAU_OP_DIV);
  assign div_zero = (mb == 24'h00_0000);
  assign div_go = accept && is_div && !div_zero;
  assign busy_o = (state_q != fau_pkg::FAU_ST_IDLE);
  assign div_res = fau_pack(div_s_q, div_e_q, {1'b0, quot, 20'h0_0000});

  fau_mant_div u_div (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(div_go),
    .dividend_i(ma),
    .divisor_i(mb),
    .done_o(div_done),
    .quot_o(quot)
  );

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_s_q <= 1'b0;
      div_e_q <= `FAU_ZERO_E;
    end
    else if (div_go)
    begin
      div_s_q <= sa ^ sb;
      div_e_q <= $signed({3'b000, ea}) - $signed({3'b000, eb}) + `FAU_BIAS;
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_q <= fau_pkg::FAU_ST_IDLE;
    else
    begin
      case (state_q)
        fau_pkg::FAU_ST_IDLE:
          if (div_go)
            state_q <= fau_pkg::FAU_ST_DIV;
        fau_pkg::FAU_ST_DIV:
          if (div_done)
            state_q <= fau_pkg::FAU_ST_IDLE;
        default:
          state_q <= fau_pkg::FAU_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // result and status flags
  // ----------------------------------------
  logic fin_ok;
  logic [34:0] fin_res;
  assign fin_ok = (accept && !is_div) || div_done;
  assign fin_res = div_done ? div_res : ((op_i == `FAU_OP_MUL) ? mul_res : add_res);

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dest_lo_o <= 16'h0000;
      dest_hi_o <= 16'h0000;
      carry_flag_o <= 1'b0;
      borrow_flag_o <= 1'b0;
      zero_flag_o <= 1'b0;
      wr_en_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      wr_en_o <= fin_ok;
      done_o <= fin_ok || (accept && is_div && div_zero);
      if (fin_ok)
      begin
        dest_lo_o <= fin_res[15:0];
        dest_hi_o <= fin_res[31:16];
        carry_flag_o <= fin_res[34];
        borrow_flag_o <= fin_res[33];
        zero_flag_o <= fin_res[32];
      end
    end
  end

  // ----------------------------------------
  // divide error
  // ----------------------------------------
  // the latch flag survives later good operations; a new error wins over its clear
  logic div_err;
  assign div_err = accept && is_div && div_zero;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      operation_error_flag_o <= 1'b0;
      operation_error_latch_flag_o <= 1'b0;
      error_code_register_o <= 16'h0000;
    end
    else
    begin
      if (div_err)
      begin
        operation_error_flag_o <= 1'b1;
        operation_error_latch_flag_o <= 1'b1;
        error_code_register_o <= `FAU_ERR_DIV0;
      end
      else
      begin
        if (accept)
          operation_error_flag_o <= 1'b0;
        if (err_latch_clr_i)
          operation_error_latch_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_ADD_ZERO_ID: assert property (
    accept && op_i == `FAU_OP_ADD && !first_operand_imm_i && ea != `FAU_EXP_ZERO && ea != `FAU_EXP_INF
      && eb == `FAU_EXP_ZERO |=> wr_en_o && {dest_hi_o, dest_lo_o} == $past(opa))
    else $error("add of zero did not return the first operand");
  AST_SUB_SELF_ZERO: assert property (
    accept && op_i == `FAU_OP_SUB && opa == opb |=> wr_en_o && zero_flag_o && dest_lo_o == 16'h0000
      && dest_hi_o == 16'h0000)
    else $error("x minus x not zero");
  AST_MUL_ZERO: assert property (
    accept && op_i == `FAU_OP_MUL && eb == `FAU_EXP_ZERO |=> wr_en_o && zero_flag_o && !carry_flag_o)
    else $error("product with zero not zero");
  AST_DIV_LATENCY: assert property (
    div_go |=> busy_o [*8] ##[20:24] (wr_en_o && !busy_o))
    else $error("divide result outside expected latency");
  AST_IMM_PASS: assert property (
    accept && op_i == `FAU_OP_ADD && first_operand_imm_i && ea != `FAU_EXP_ZERO && ea != `FAU_EXP_INF
      && eb == `FAU_EXP_ZERO |=> {dest_hi_o, dest_lo_o} == $past(first_operand_imm_val_i))
    else $error("immediate operand not used");
  AST_CARRY_INF: assert property (
    wr_en_o && carry_flag_o |-> dest_hi_o[14:7] == `FAU_EXP_INF && !borrow_flag_o)
    else $error("carry without saturated result");
  AST_BORROW_ZERO: assert property (
    wr_en_o && borrow_flag_o |-> dest_hi_o[14:0] == 15'h0000 && dest_lo_o == 16'h0000)
    else $error("borrow with nonzero result");
  AST_ZERO_FLAG: assert property (
    wr_en_o |-> zero_flag_o == (dest_hi_o[14:0] == 15'h0000 && dest_lo_o == 16'h0000 && !borrow_flag_o))
    else $error("zero flag disagrees with result");
  AST_DIV0_ERR: assert property (
    div_err |=> !wr_en_o && done_o && operation_error_flag_o && operation_error_latch_flag_o
      && error_code_register_o == `FAU_ERR_DIV0 && $stable(dest_lo_o) && !busy_o)
    else $error("divide by zero handling wrong");
  AST_FLAGS_HOLD: assert property (
    !wr_en_o |-> $stable(carry_flag_o) && $stable(borrow_flag_o) && $stable(zero_flag_o))
    else $error("status flags moved without an operation");

endmodule : fau_top

// ===== verif/fau_issue_model.sv
/*
  issuing-side model: presents one floating-point operand as a register pair or as an immediate.
  assumes the bench sets value and form just after a clock edge and holds them until done.
*/
`timescale 1ns/1ps

module fau_issue_model (
  input wire logic [31:0] value_i,
  input wire logic imm_i,
  output logic [31:0] imm_val_o,
  output logic [15:0] lo_o,
  output logic [15:0] hi_o
);
  // ----------------------------------------
  // operand presentation
  // ----------------------------------------
  // the unused form carries the inverted value, so a wrong select never passes by luck
  assign imm_val_o = imm_i ? value_i : ~value_i;
  assign lo_o = imm_i ? ~value_i[15:0] : value_i[15:0];
  assign hi_o = imm_i ? ~value_i[31:16] : value_i[31:16];
endmodule : fau_issue_model

// ===== verif/tb_top.sv
/*
  self-checking bench of the floating-point unit: corner cases, then seeded random operations.
  assumes the unit answers within 40 cycles and that small integers are exact in single precision.
*/
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
      n_mismatch++; \
    end \
  end

module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [1:0] op = 2'h0;
  logic a_imm = 1'b0;
  logic b_imm = 1'b0;
  logic err_clr = 1'b0;
  logic [31:0] a_val = 32'h0000_0000;
  logic [31:0] b_val = 32'h0000_0000;
  logic [31:0] a_iv, b_iv;
  logic [15:0] a_lo, a_hi, b_lo, b_hi, dest_lo_o, dest_hi_o, error_code_register_o;
  logic busy_o, done_o, wr_en_o, carry_flag_o, borrow_flag_o, zero_flag_o;
  logic operation_error_flag_o, operation_error_latch_flag_o;
  int n_mismatch = 0;
  int check_count = 0;
  int seed;

  always #25 clk = ~clk;

  fau_issue_model u_first (.value_i(a_val), .imm_i(a_imm), .imm_val_o(a_iv), .lo_o(a_lo), .hi_o(a_hi));
  fau_issue_model u_second (.value_i(b_val), .imm_i(b_imm), .imm_val_o(b_iv), .lo_o(b_lo), .hi_o(b_hi));

  fau_top DUT (
    .clock_i(clk),
    .resetn_i(resetn),
    .start_i(start),
    .op_i(op),
    .first_operand_imm_i(a_imm),
    .first_operand_imm_val_i(a_iv),
    .first_operand_lo_i(a_lo),
    .first_operand_hi_i(a_hi),
    .second_operand_imm_i(b_imm),
    .second_operand_imm_val_i(b_iv),
    .second_operand_lo_i(b_lo),
    .second_operand_hi_i(b_hi),
    .err_latch_clr_i(err_clr),
    .busy_o(busy_o),
    .done_o(done_o),
    .wr_en_o(wr_en_o),
    .dest_lo_o(dest_lo_o),
    .dest_hi_o(dest_hi_o),
    .carry_flag_o(carry_flag_o),
    .borrow_flag_o(borrow_flag_o),
    .zero_flag_o(zero_flag_o),
    .operation_error_flag_o(operation_error_flag_o),
    .operation_error_latch_flag_o(operation_error_latch_flag_o),
    .error_code_register_o(error_code_register_o)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // expected words are built field by field; exact while the magnitude stays below 2^24
  function automatic logic [31:0] fb(input int v);
    logic [31:0] m;
    int p;
    m = 32'(v < 0 ? -v : v);
    p = 0;
    for (int i = 0; i < 32; i++)
      if (m[i])
        p = i;
    if (m == 32'h0000_0000)
      return 32'h0000_0000;
    m = m << (23 - p);
    return {v < 0, 8'(127 + p), m[22:0]};
  endfunction : fb

  // one operation; operand forms are drawn at random; poke issues a start while busy
  task automatic run(input logic [1:0] o, input logic [31:0] a, b, ex,
                     input logic c, bw, z, input bit dz, poke);
    int n;
    logic [31:0] prev;
    logic [2:0] pf;
    // one idle edge first, so start never falls and rises within one time step
    @(posedge clk);
    #1;
    prev = {dest_hi_o, dest_lo_o};
    pf = {carry_flag_o, borrow_flag_o, zero_flag_o};
    op = o;
    a_val = a;
    b_val = b;
    {a_imm, b_imm} = 2'($random(seed));
    start = 1'b1;
    @(posedge clk);
    #1;
    `CHK("busy", o == fau_pkg::FAU_DIV && !dz, busy_o);
    if (poke)
    begin
      op = fau_pkg::FAU_ADD;
      @(posedge clk);
      #1;
    end
    start = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      n_mismatch++;
      wrap_up();
    end
    `CHK("write enable", !dz, wr_en_o);
    `CHK("result", dz ? prev : ex, {dest_hi_o, dest_lo_o});
    `CHK("flags", dz ? pf : {c, bw, z}, {carry_flag_o, borrow_flag_o, zero_flag_o});
    `CHK("error flag", dz, operation_error_flag_o);
    if (dz) `CHK("error code", 16'h0E19, error_code_register_o);
    if (dz) `CHK("error latch", 1'b1, operation_error_latch_flag_o);
  endtask : run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int a;
    int b;
    int r;
    logic [1:0] o;
    seed = 32'hbab8_82a9;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    run(fau_pkg::FAU_ADD, fb(3), fb(4), fb(7), 0, 0, 0, 0, 0);
    run(fau_pkg::FAU_SUB, fb(7), fb(7), 32'h0000_0000, 0, 0, 1, 0, 0);
    run(fau_pkg::FAU_MUL, 32'h7000_0000, 32'h7000_0000, 32'h7F80_0000, 1, 0, 0, 0, 0);
    run(fau_pkg::FAU_MUL, 32'hF000_0000, 32'h7000_0000, 32'hFF80_0000, 1, 0, 0, 0, 0);
    run(fau_pkg::FAU_ADD, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h7F80_0000, 1, 0, 0, 0, 0);
    run(fau_pkg::FAU_SUB, fb(-3), fb(5), fb(-8), 0, 0, 0, 0, 0);
    run(fau_pkg::FAU_MUL, 32'h1000_0000, 32'h1000_0000, 32'h0000_0000, 0, 1, 0, 0, 0);
    run(fau_pkg::FAU_DIV, 32'h0080_0000, 32'h7000_0000, 32'h0000_0000, 0, 1, 0, 0, 0);
    run(fau_pkg::FAU_DIV, fb(12), fb(4), fb(3), 0, 0, 0, 0, 1);
    run(fau_pkg::FAU_DIV, fb(5), 32'h0000_0000, 32'h0000_0000, 0, 0, 0, 1, 0);
    run(fau_pkg::FAU_ADD, fb(-3), fb(3), 32'h0000_0000, 0, 0, 1, 0, 0);
    err_clr = 1'b1;
    @(posedge clk);
    #1;
    err_clr = 1'b0;
    `CHK("error latch", 1'b0, operation_error_latch_flag_o);
    // exponent zero divisor is flushed to zero, so it must abort as well
    run(fau_pkg::FAU_DIV, fb(9), 32'h0000_0001, 32'h0000_0000, 0, 0, 0, 1, 0);
    // reset with the unit idle clears the result and the error record
    resetn = 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset result", 32'h0000_0000, {dest_hi_o, dest_lo_o});
    `CHK("reset error code", 16'h0000, error_code_register_o);
    `CHK("reset error latch", 1'b0, operation_error_latch_flag_o);
    resetn = 1'b1;
    // zero second operand in both operand forms: identity for add, zero product for multiply
    repeat (6)
    begin
      run(fau_pkg::FAU_ADD, fb(5), 32'h0000_0000, fb(5), 0, 0, 0, 0, 0);
      run(fau_pkg::FAU_MUL, fb(-6), 32'h0000_0000, 32'h0000_0000, 0, 0, 1, 0, 0);
    end
    repeat (40)
    begin
      o = 2'($random(seed));
      a = $random(seed) % 100;
      b = $random(seed) % 100;
      if (a == 0)
        a = 1;
      if (b == 0)
        b = -1;
      case (o)
        fau_pkg::FAU_ADD: r = a + b;
        fau_pkg::FAU_SUB: r = a - b;
        fau_pkg::FAU_MUL: r = a * b;
        default:
        begin
          r = a;
          a = a * b;
        end
      endcase
      run(o, fb(a), fb(b), fb(r), 0, 0, r == 0, 0, 0);
    end
    wrap_up();
  end
endmodule : tb_top
